// >>> pkg/dpc_map.vh
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// Summary of operation
// - Two independent 8-bit down counters are provided, each fed by its own 6-bit prescaler.
// - The second prescaler takes the internal or the external clock; the first takes internal only.
// - Each prescaler divides its source by a programmable integer from 1 to 64.
// - Each counter steps down on its prescaler output from a loaded count of 1 to 256.
// - When counter and prescaler both end their count, that timer's own request is raised.
// - Software can start, stop, resume from the current value, or restart from the load value.
// - In single-pass mode a counter halts at zero and does not reload.
// - In continuous mode a counter reloads its initial value at end of count and keeps going.
// - Counters read back at any time without disturbance; prescalers are not readable.
// - The second timer counts internal clock divided by four or the external count pin.
// - The external pin acts as clock, retriggerable trigger, one-shot trigger, or gate.
// - With low-noise set, the divide-by-two stage is bypassed so the timer clock is the crystal.

// Register byte addresses
`define DPC_CTRL_ADDR   8'h00
`define DPC_LOAD0_ADDR  8'h04
`define DPC_LOAD1_ADDR  8'h08
`define DPC_PRE0_ADDR   8'h0c
`define DPC_PRE1_ADDR   8'h10
`define DPC_CNT0_ADDR   8'h14
`define DPC_CNT1_ADDR   8'h18
`define DPC_STAT_ADDR   8'h1c
`define DPC_MASK_ADDR   8'h20

// Control fields
`define DPC_CTRL_RUN0    0
`define DPC_CTRL_RUN1    1
`define DPC_CTRL_LOAD0   2
`define DPC_CTRL_LOAD1   3
`define DPC_CTRL_CONT0   4
`define DPC_CTRL_CONT1   5
`define DPC_CTRL_EXTSRC  6
`define DPC_CTRL_LONOISE 7
`define DPC_CTRL_PMODE   9:8
`define DPC_CTRL_RST     10'h000

// Pin modes
`define DPC_PM_CLOCK  2'h0
`define DPC_PM_GATE   2'h1
`define DPC_PM_TRIG   2'h2
`define DPC_PM_RETRIG 2'h3

// Internal timer tick spacing
`define DPC_XTAL_DIV      2
`define DPC_T1_INT_DIV    4
`define DPC_PRE_RST       6'h00
`endif

// >>> design/dpc_sync.v
`timescale 1ns/1ps
module dpc_sync (
	input  wire core_clk,
	input  wire rstn,
	input  wire clkEn,
	input  wire pinIn,
	output reg  pinSync
);
	reg stage1_q;

	always @(posedge core_clk) begin
		if (!rstn) begin
			stage1_q <= 1'b0;
			pinSync  <= 1'b0;
		end else if (clkEn) begin
			stage1_q <= pinIn;
			pinSync  <= stage1_q;
		end
	end
endmodule

// >>> design/dpc_timer.v
`timescale 1ns/1ps
`include "dpc_map.vh"
// One prescaled 8-bit down counter.
module dpc_timer #(
	parameter PRE_W = 6,
	parameter CNT_W = 8
) (
	input  wire             core_clk,
	input  wire             rstn,
	input  wire             clkEn,
	input  wire             tick,
	input  wire             run,
	input  wire             restart,
	input  wire             contMode,
	input  wire [PRE_W-1:0] preLoad,
	input  wire [CNT_W-1:0] cntLoad,
	output reg  [CNT_W-1:0] count_q,
	output reg              active_q,
	output reg              endPulse_q
);
	localparam [PRE_W-1:0] PRE_ONE = {{(PRE_W-1){1'b0}}, 1'b1};

	reg  [PRE_W-1:0] pre_q;
	wire             preEnd = (pre_q == PRE_ONE) ||
	                          (pre_q == {PRE_W{1'b0}} && preLoad == PRE_ONE);

	// Zero in a load field means the full span, 64 or 256
	always @(posedge core_clk) begin
		if (!rstn) begin
			pre_q      <= `DPC_PRE_RST;
			count_q    <= {CNT_W{1'b0}};
			active_q   <= 1'b0;
			endPulse_q <= 1'b0;
		end else if (clkEn) begin
			endPulse_q <= 1'b0;
			if (restart) begin
				pre_q    <= preLoad;
				count_q  <= cntLoad;
				active_q <= 1'b1;
			end else if (run && active_q && tick) begin
				if (preEnd) begin
					pre_q <= preLoad;
					if (count_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
						endPulse_q <= 1'b1;
						if (contMode)
							count_q <= cntLoad;
						else begin
							count_q  <= {CNT_W{1'b0}};
							active_q <= 1'b0;
						end
					end else
						count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
				end else
					pre_q <= pre_q - {{(PRE_W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

// >>> design/dpc_top.v
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "dpc_map.vh"
module dpc_top (
	input  wire        core_clk,
	input  wire        rstn,
	input  wire        clkEn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        externalCountPin,
	output reg         firstCounterRequest,
	output reg         secondCounterRequest,
	output reg         irq
);
	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	reg [9:0] ctrl_q;
	reg [7:0] load0_q;
	reg [7:0] load1_q;
	reg [5:0] pre0_q;
	reg [5:0] pre1_q;
	reg [1:0] stat_q;
	reg [1:0] mask_q;
	reg       restart0_q;
	reg       restart1_q;

	wire [7:0] count0;
	wire [7:0] count1;
	wire       active0;
	wire       active1;
	wire       end0;
	wire       end1;
	wire       pinSync;

	wire access = psel && penable;
	wire wrEn   = access && pwrite && pready;

	//--------------------------------------------------------------
	// Internal timer clock
	//--------------------------------------------------------------
	// Crystal is core_clk; divide-by-two is skipped in low-noise mode
	reg       xtalDiv_q;
	reg [1:0] t1Div_q;
	wire      intTick = ctrl_q[`DPC_CTRL_LONOISE] | xtalDiv_q;

	always @(posedge core_clk) begin
		if (!rstn) begin
			xtalDiv_q <= 1'b0;
			t1Div_q   <= 2'h0;
		end else if (clkEn) begin
			xtalDiv_q <= ~xtalDiv_q;
			if (intTick)
				t1Div_q <= t1Div_q + 2'h1;
		end
	end

	wire t1IntTick = intTick && (t1Div_q == 2'h3);

	//--------------------------------------------------------------
	// External pin
	//--------------------------------------------------------------
	dpc_sync uSync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.clkEn    (clkEn),
		.pinIn    (externalCountPin),
		.pinSync  (pinSync)
	);

	reg  pinPrev_q;
	always @(posedge core_clk) begin
		if (!rstn)
			pinPrev_q <= 1'b0;
		else if (clkEn)
			pinPrev_q <= pinSync;
	end
	wire pinRise = pinSync && !pinPrev_q;
	wire [1:0] pmode = ctrl_q[`DPC_CTRL_PMODE];

	// Second timer tick and trigger selection
	reg t1Tick;
	reg t1Trig;
	always @* begin
		t1Tick = t1IntTick;
		t1Trig = 1'b0;
		if (ctrl_q[`DPC_CTRL_EXTSRC]) begin
			case (pmode)
				`DPC_PM_CLOCK:  t1Tick = pinRise;
				`DPC_PM_GATE:   t1Tick = t1IntTick && pinSync;
				`DPC_PM_TRIG:   t1Trig = pinRise && !active1;
				`DPC_PM_RETRIG: t1Trig = pinRise;
				default:        t1Tick = t1IntTick;
			endcase
		end
	end

	// In trigger modes the run bit arms; the pin edge does the restart
	wire trigMode = ctrl_q[`DPC_CTRL_EXTSRC] && pmode[1];

	//--------------------------------------------------------------
	// Timers
	//--------------------------------------------------------------
	dpc_timer uTimer0 (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.clkEn      (clkEn),
		.tick       (t1IntTick),
		.run        (ctrl_q[`DPC_CTRL_RUN0]),
		.restart    (restart0_q),
		.contMode   (ctrl_q[`DPC_CTRL_CONT0]),
		.preLoad    (pre0_q),
		.cntLoad    (load0_q),
		.count_q    (count0),
		.active_q   (active0),
		.endPulse_q (end0)
	);

	dpc_timer uTimer1 (
		.core_clk   (core_clk),
		.rstn       (rstn),
		.clkEn      (clkEn),
		.tick       (t1Tick),
		.run        (ctrl_q[`DPC_CTRL_RUN1]),
		.restart    (restart1_q | (t1Trig && ctrl_q[`DPC_CTRL_RUN1] && trigMode)),
		.contMode   (ctrl_q[`DPC_CTRL_CONT1]),
		.preLoad    (pre1_q),
		.cntLoad    (load1_q),
		.count_q    (count1),
		.active_q   (active1),
		.endPulse_q (end1)
	);

	//--------------------------------------------------------------
	// APB slave
	//--------------------------------------------------------------
	always @(posedge core_clk) begin
		if (!rstn) begin
			ctrl_q     <= `DPC_CTRL_RST;
			load0_q    <= 8'h00;
			load1_q    <= 8'h00;
			pre0_q     <= `DPC_PRE_RST;
			pre1_q     <= `DPC_PRE_RST;
			mask_q     <= 2'h0;
			stat_q     <= 2'h0;
			restart0_q <= 1'b0;
			restart1_q <= 1'b0;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			prdata     <= 32'h00000000;
		end else if (clkEn) begin
			restart0_q <= 1'b0;
			restart1_q <= 1'b0;
			pready     <= access && !pready;
			pslverr    <= 1'b0;
			if (access && !pready) begin
				prdata <= 32'h00000000;
				case (paddr)
					`DPC_CTRL_ADDR:  prdata <= {22'h000000, ctrl_q};
					`DPC_LOAD0_ADDR: prdata <= {24'h000000, load0_q};
					`DPC_LOAD1_ADDR: prdata <= {24'h000000, load1_q};
					`DPC_PRE0_ADDR:  prdata <= 32'h00000000;
					`DPC_PRE1_ADDR:  prdata <= 32'h00000000;
					`DPC_CNT0_ADDR:  prdata <= {23'h000000, active0, count0};
					`DPC_CNT1_ADDR:  prdata <= {23'h000000, active1, count1};
					`DPC_STAT_ADDR:  prdata <= {30'h00000000, stat_q};
					`DPC_MASK_ADDR:  prdata <= {30'h00000000, mask_q};
					default:         pslverr <= 1'b1;
				endcase
			end
			// Pulse bits: a written one restarts that counter from its load value, except LOAD1 while a trigger mode is set
			if (wrEn) begin
				case (paddr)
					`DPC_CTRL_ADDR: begin
						ctrl_q     <= pwdata[9:0];
						restart0_q <= pwdata[`DPC_CTRL_LOAD0];
						// Judged on the new mode, so entering a trigger mode cannot start it
						restart1_q <= pwdata[`DPC_CTRL_LOAD1] &&
						              !(pwdata[`DPC_CTRL_EXTSRC] && pwdata[9]);
					end
					`DPC_LOAD0_ADDR: load0_q <= pwdata[7:0];
					`DPC_LOAD1_ADDR: load1_q <= pwdata[7:0];
					`DPC_PRE0_ADDR:  pre0_q  <= pwdata[5:0];
					`DPC_PRE1_ADDR:  pre1_q  <= pwdata[5:0];
					`DPC_MASK_ADDR:  mask_q  <= pwdata[1:0];
					default: ;
				endcase
			end
			// Set wins over a write-one clear
			stat_q[0] <= end0 | (stat_q[0] & ~(wrEn && paddr == `DPC_STAT_ADDR && pwdata[0]));
			stat_q[1] <= end1 | (stat_q[1] & ~(wrEn && paddr == `DPC_STAT_ADDR && pwdata[1]));
		end
	end

	//--------------------------------------------------------------
	// Requests
	//--------------------------------------------------------------
	always @(posedge core_clk) begin
		if (!rstn) begin
			firstCounterRequest  <= 1'b0;
			secondCounterRequest <= 1'b0;
			irq                  <= 1'b0;
		end else if (clkEn) begin
			firstCounterRequest  <= end0;
			secondCounterRequest <= end1;
			irq                  <= |(stat_q & mask_q);
		end
	end
endmodule

// >>> test/dpc_sva.sv
`timescale 1ns/1ps
module dpc_sva (
	input wire        core_clk,
	input wire        rstn,
	input wire        clkEn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	input wire        externalCountPin,
	input wire        firstCounterRequest,
	input wire        secondCounterRequest,
	input wire        irq
);
	// ----------
	// Checks
	// ----------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn || !clkEn);
	a_req0_pulse: assert property (firstCounterRequest |=> !firstCounterRequest)
		else $error("first request wider than one cycle");
	a_req1_pulse: assert property (secondCounterRequest |=> !secondCounterRequest)
		else $error("second request wider than one cycle");
	// Fastest legal period is one prescaled tick of four core cycles
	a_req0_gap: assert property (firstCounterRequest |=> !firstCounterRequest [*3])
		else $error("first requests too close");
	a_ready_wait: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_addr: assert property (pslverr |-> pready && (paddr > 8'h20 || paddr[1:0] != 2'h0))
		else $error("error on mapped address");
	a_err_rdata: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("error read not zero");
	a_irq_fall: assert property ($fell(irq) |-> $past(psel && pwrite, 1)
		|| $past(psel && pwrite, 2) || $past(psel && pwrite, 3))
		else $error("interrupt dropped without a write");
	c_req0: cover property (firstCounterRequest);
	c_req1: cover property (secondCounterRequest);
	c_err: cover property (pslverr);
endmodule

// >>> test/dpc_pin_src.sv
`timescale 1ns/1ps
module dpc_pin_src (
	input  wire  core_clk,
	input  wire  fire,
	output logic pin
);
	int n = 0;
	initial pin = 1'b0;
	// Six cycles high, six low: wider than the minimum pin widths
	always @(posedge core_clk) begin
		if (fire && n == 0)
			n <= 12;
		else if (n > 0)
			n <= n - 1;
		pin <= (n > 6);
	end
endmodule

// >>> test/tb_dual_prescaled_down_counter.sv
`timescale 1ns/1ps
module tb_dual_prescaled_down_counter;
	logic        core_clk = 0;
	logic        rstn = 0;
	logic        clkEn = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        fire = 0;
	logic        lastErr;
	logic [31:0] rd;
	logic [31:0] c;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         pin;
	wire         firstCounterRequest;
	wire         secondCounterRequest;
	wire         irq;
	int          error_cnt = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          n;
	int          sel[6] = '{0, 0, 0, 0, 1, 1};
	int          pre[6] = '{1, 3, 0, 1, 2, 1};
	int          ld[6] = '{1, 5, 1, 0, 3, 1};
	int          ln[6] = '{0, 0, 1, 1, 0, 1};
	always #4 core_clk = ~core_clk;
	dpc_top dpc_top_inst (.core_clk, .rstn, .clkEn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .externalCountPin(pin), .firstCounterRequest,
		.secondCounterRequest, .irq);
	dpc_pin_src dpc_pin_src_inst (.core_clk, .fire, .pin);
	// ----------
	// Tasks
	// ----------
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task automatic chk(input [31:0] g, input [31:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input [7:0] a, input [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input [7:0] a, input [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic waitReq(input int s, output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			#1;
			k++;
		end while ((s ? secondCounterRequest : firstCounterRequest) !== 1'b1);
	endtask
	task automatic pulse;
		@(posedge core_clk);
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		rdc(8'h00, 32'h0);
		rdc(8'h24, 32'h0);
		chk(lastErr, 1);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			c = (32'h15 << sel[i]) | (ln[i] << 7);
			wr(8'(8'h0c + 4 * sel[i]), pre[i]);
			wr(8'(8'h04 + 4 * sel[i]), ld[i]);
			wr(8'h00, c);
			rdc(8'h00, c);
			waitReq(sel[i], n);
			waitReq(sel[i], n);
			chk(n, (pre[i] ? pre[i] : 64) * (ld[i] ? ld[i] : 256) * (ln[i] ? 4 : 8));
			wr(8'h00, 32'h0);
		end
		$display("test period done");
		wr(8'h1c, 32'h3);
		wr(8'h04, 32'h2);
		wr(8'h0c, 32'h1);
		wr(8'h00, 32'h5);
		waitReq(0, n);
		n = 0;
		repeat (80) begin
			@(posedge core_clk);
			#1;
			if (firstCounterRequest === 1'b1)
				n++;
		end
		chk(n, 0);
		rdc(8'h14, 32'h0);
		rdc(8'h1c, 32'h1);
		chk(irq, 0);
		wr(8'h20, 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		chk(irq, 1);
		wr(8'h1c, 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		chk(irq, 0);
		$display("test single pass done");
		wr(8'h04, 32'ha);
		wr(8'h00, 32'h5);
		repeat (30) @(posedge core_clk);
		wr(8'h00, 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		c = rd;
		repeat (40) @(posedge core_clk);
		rdc(8'h14, c);
		wr(8'h00, 32'h1);
		waitReq(0, n);
		chk(n <= 8 * c[7:0] + 8, 1);
		$display("test stop resume done");
		wr(8'h10, 32'h1);
		wr(8'h08, 32'h3);
		wr(8'h00, 32'h4a);
		repeat (2) begin
			pulse();
			repeat (16) @(posedge core_clk);
		end
		rdc(8'h18, 32'h101);
		pulse();
		waitReq(1, n);
		chk(n <= 16, 1);
		rdc(8'h18, 32'h0);
		$display("test pin clock done");
		wr(8'h08, 32'h10);
		wr(8'h00, 32'h24a);
		rdc(8'h18, 32'h0);
		pulse();
		repeat (40) @(posedge core_clk);
		pulse();
		waitReq(1, n);
		chk(n <= 100, 1);
		wr(8'h00, 32'h34a);
		rdc(8'h18, 32'h0);
		pulse();
		repeat (40) @(posedge core_clk);
		pulse();
		waitReq(1, n);
		chk(n > 100, 1);
		$display("test trigger done");
		wr(8'h08, 32'h2);
		wr(8'h00, 32'h14a);
		repeat (40) @(posedge core_clk);
		rdc(8'h18, 32'h102);
		$display("test gate done");
		tally_and_finish();
	end
endmodule
bind dpc_top dpc_sva dpc_sva_inst (.core_clk, .rstn, .clkEn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .externalCountPin, .firstCounterRequest,
	.secondCounterRequest, .irq);
